// ---- logic/ubd_divide.sv ----
// unsigned 16 by 8 divide unit with instruction decode and apb register access
//
// Overview of operation
// - pair divided by source, quotient to accumulator
// - valid result puts remainder in low byte
// - high byte stays untouched; source too unless it is a or the low byte
// - valid: clear v and s, z from quotient
// - zero divisor: keep a, set z v, trap
// - quotient too big: keep a, set v, trap
// - flags final in the same cycle the trap is raised
// - z on zero quotient or divisor, s cleared
// - v on zero divisor or quotient overflow
// - register form, field 110 reads memory
// - constant form with one immediate byte
// - absolute form, address low byte first
// - indexed form, base from selector field
// - two register sum form address
// - prefix bit picks first or second index
// - half form picks high or low byte
// - pc relative form with 16-bit displacement
// - stack offset form added to stack pointer
`timescale 1ns/1ps
module ubd_divide (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic division_trap
);
    typedef enum logic [2:0] {
        UBD_S_IDLE, UBD_S_DECODE, UBD_S_MEMWAIT, UBD_S_DIVIDE, UBD_S_FINISH, UBD_S_TRAP
    } ubd_state_t;

    ubd_state_t state;
    logic [15:0] dividend_pair_reg;
    logic [7:0] acc;
    logic [7:0] flags;
    logic [31:0] insn0;
    logic [7:0] insn1;
    logic [31:0] gpr;
    logic [15:0] first_index_reg;
    logic [15:0] second_index_reg;
    logic [15:0] stack_ptr;
    logic [15:0] prog_ctr;
    logic [15:0] eff_addr;
    ubd_pkg::ubd_mode_t mode;
    logic done_flag;
    logic trap_flag;
    logic illegal_flag;
    logic [7:0] divisor;
    logic [15:0] quot;
    logic [8:0] rem;
    logic [4:0] step;

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode
    logic setup_ph;
    logic wr_en;
    logic addr_ok;
    logic busy;
    logic [7:0] off;
    assign off = paddr[7:0];
    assign setup_ph = psel && !penable;
    // a refused address must not land on a register that shares its low bits
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign busy = (state != UBD_S_IDLE);
    assign pready = 1'b1;
    // only word aligned offsets inside the map are claimed
    assign addr_ok = (paddr[31:8] == 24'h00_0000) && (off[1:0] == 2'b00) && (off <= 8'h28);

    logic wr_ctrl;
    logic wr_status;
    logic wr_mem;
    // software writes to operand registers are dropped while the unit is busy
    logic wr_idle;
    assign wr_ctrl = wr_en && (off == ubd_pkg::OFF_CTRL);
    assign wr_status = wr_en && (off == ubd_pkg::OFF_STATUS);
    assign wr_mem = wr_en && (off == ubd_pkg::OFF_MEM) && (state == UBD_S_MEMWAIT);
    assign wr_idle = wr_en && !busy;

    ////////////////////////////////////////////////////////////////////////////////
    // instruction decode
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
    assign b0 = insn0[7:0];
    assign b1 = insn0[15:8];
    assign b2 = insn0[23:16];
    assign b3 = insn0[31:24];
    assign b4 = insn1;

    logic [15:0] disp16;
    logic [15:0] disp8;
    logic [15:0] idx_sel;
    logic b1_op;
    logic b2_op;
    assign disp16 = {b4, b3};
    assign disp8 = {{8{b3[7]}}, b3};
    assign idx_sel = b0[ubd_pkg::PFX_INDEX_BIT] ? second_index_reg : first_index_reg;
    assign b1_op = (b1[7:6] == ubd_pkg::HEAD_OP) && (b1[2:0] == ubd_pkg::TAIL_UNSIGNED_SHORT_DIVIDE);
    assign b2_op = (b2[7:6] == ubd_pkg::HEAD_OP) && (b2[2:0] == ubd_pkg::TAIL_UNSIGNED_SHORT_DIVIDE);

    logic dec_bad;
    logic dec_mem;
    logic [7:0] dec_src;
    logic [15:0] dec_ea;
    ubd_pkg::ubd_mode_t dec_mode;
    // decode is a pure function of the staged opcode bytes and the operand registers
    always_comb begin
        dec_bad = 1'b0;
        dec_mem = 1'b0;
        dec_src = 8'h00;
        dec_ea = 16'h0000;
        dec_mode = ubd_pkg::UBD_M_REG;
        if (b0 == ubd_pkg::PFX_MAIN && b1_op) begin
            unique case (b1[5:3])
                3'h0: dec_src = gpr[31:24];
                3'h1: dec_src = gpr[23:16];
                3'h2: dec_src = gpr[15:8];
                3'h3: dec_src = gpr[7:0];
                3'h4: dec_src = dividend_pair_reg[15:8];
                3'h5: dec_src = dividend_pair_reg[7:0];
                ubd_pkg::R_MEM: begin
                    dec_mem = 1'b1;
                    dec_ea = dividend_pair_reg;
                    dec_mode = ubd_pkg::UBD_M_POINTER;
                end
                ubd_pkg::R_ACC: dec_src = acc;
            endcase
        end else if ((b0 == ubd_pkg::PFX_SECOND || b0 == ubd_pkg::PFX_FIRST)
                     && b1 == ubd_pkg::PFX_MAIN && b2_op) begin
            unique case (b2[5:3])
                ubd_pkg::F_CONST: begin
                    if (b0 == ubd_pkg::PFX_SECOND) begin
                        dec_src = b3;
                        dec_mode = ubd_pkg::UBD_M_CONST;
                    end else begin
                        dec_mem = 1'b1;
                        dec_ea = disp16;
                        dec_mode = ubd_pkg::UBD_M_ABS;
                    end
                end
                ubd_pkg::F_PCREL: begin
                    dec_mem = 1'b1;
                    if (b0 == ubd_pkg::PFX_SECOND) begin
                        dec_ea = 16'(prog_ctr + disp16);
                        dec_mode = ubd_pkg::UBD_M_PCREL;
                    end else begin
                        dec_ea = 16'(stack_ptr + disp16);
                        dec_mode = ubd_pkg::UBD_M_STACK;
                    end
                end
                ubd_pkg::F_SEL1, ubd_pkg::F_SEL2, ubd_pkg::F_SEL3: begin
                    dec_mem = 1'b1;
                    if (b0 == ubd_pkg::PFX_SECOND) begin
                        dec_mode = ubd_pkg::UBD_M_INDEXED;
                        unique case (b2[4:3])
                            2'h1: dec_ea = 16'(first_index_reg + disp16);
                            2'h2: dec_ea = 16'(second_index_reg + disp16);
                            default: dec_ea = 16'(dividend_pair_reg + disp16);
                        endcase
                    end else begin
                        dec_mode = ubd_pkg::UBD_M_SUM;
                        unique case (b2[4:3])
                            2'h1: dec_ea = 16'(dividend_pair_reg + first_index_reg);
                            2'h2: dec_ea = 16'(dividend_pair_reg + second_index_reg);
                            default: dec_ea = 16'(first_index_reg + second_index_reg);
                        endcase
                    end
                end
                ubd_pkg::F_HIGH: begin
                    dec_src = idx_sel[15:8];
                    dec_mode = ubd_pkg::UBD_M_HALF;
                end
                ubd_pkg::F_LOW: begin
                    dec_src = idx_sel[7:0];
                    dec_mode = ubd_pkg::UBD_M_HALF;
                end
                ubd_pkg::F_SHORT: begin
                    dec_mem = 1'b1;
                    dec_ea = 16'(idx_sel + disp8);
                    dec_mode = ubd_pkg::UBD_M_SHORT;
                end
            endcase
        end else begin
            dec_bad = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // divisor load: straight from decode or from the memory byte software supplies
    logic div_load;
    logic [7:0] div_value;
    assign div_load = (state == UBD_S_DECODE && !dec_bad && !dec_mem) || wr_mem;
    assign div_value = wr_mem ? pwdata[7:0] : dec_src;

    // sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= UBD_S_IDLE;
        end else begin
            unique case (state)
                UBD_S_IDLE: begin
                    if (wr_ctrl && pwdata[ubd_pkg::CTRL_START]) begin
                        state <= UBD_S_DECODE;
                    end
                end
                UBD_S_DECODE: begin
                    if (dec_bad) begin
                        state <= UBD_S_IDLE;
                    end else if (dec_mem) begin
                        state <= UBD_S_MEMWAIT;
                    end else begin
                        state <= (div_value == 8'h00) ? UBD_S_FINISH : UBD_S_DIVIDE;
                    end
                end
                UBD_S_MEMWAIT: begin
                    if (wr_mem) begin
                        state <= (div_value == 8'h00) ? UBD_S_FINISH : UBD_S_DIVIDE;
                    end
                end
                UBD_S_DIVIDE: begin
                    if (step == 5'h01) begin
                        state <= UBD_S_FINISH;
                    end
                end
                UBD_S_FINISH: begin
                    if (divisor == 8'h00 || quot[15:8] != 8'h00) begin
                        state <= UBD_S_TRAP;
                    end else begin
                        state <= UBD_S_IDLE;
                    end
                end
                UBD_S_TRAP: state <= UBD_S_IDLE;
            endcase
        end
    end

    // addressing mode and effective address seen by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= ubd_pkg::UBD_M_REG;
            eff_addr <= 16'h0000;
        end else if (state == UBD_S_DECODE && !dec_bad) begin
            mode <= dec_mode;
            eff_addr <= dec_ea;
        end
    end

    logic [8:0] trial;
    assign trial = {rem[7:0], quot[15]};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divisor <= 8'h00;
            quot <= 16'h0000;
            rem <= 9'h000;
            step <= 5'h00;
        end else if (div_load) begin
            divisor <= div_value;
            quot <= dividend_pair_reg;
            rem <= 9'h000;
            step <= ubd_pkg::DIV_STEPS;
        end else if (state == UBD_S_DIVIDE) begin
            // one quotient bit per cycle, sixteen cycles in all
            if (trial >= {1'b0, divisor}) begin
                rem <= 9'(trial - {1'b0, divisor});
                quot <= {quot[14:0], 1'b1};
            end else begin
                rem <= trial;
                quot <= {quot[14:0], 1'b0};
            end
            step <= 5'(step - 5'h01);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outcome of the finished divide
    logic res_zero_div;
    logic res_ovf;
    assign res_zero_div = (divisor == 8'h00);
    assign res_ovf = (quot[15:8] != 8'h00);

    // high byte never written by the divide
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dividend_pair_reg <= ubd_pkg::PAIR_RST;
        end else if (wr_idle && off == ubd_pkg::OFF_PAIR) begin
            dividend_pair_reg <= pwdata[15:0];
        end else if (state == UBD_S_FINISH && !res_zero_div && !res_ovf) begin
            dividend_pair_reg[7:0] <= rem[7:0];
        end
    end

    // accumulator and flag byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= ubd_pkg::ACCFLAGS_RST[15:8];
            flags <= ubd_pkg::ACCFLAGS_RST[7:0];
        end else if (wr_idle && off == ubd_pkg::OFF_ACCFLAGS) begin
            acc <= pwdata[15:8];
            flags <= pwdata[7:0];
        end else if (state == UBD_S_FINISH) begin
            flags[ubd_pkg::FLAG_S] <= 1'b0;
            flags[ubd_pkg::FLAG_V] <= res_zero_div || res_ovf;
            if (res_zero_div) begin
                flags[ubd_pkg::FLAG_Z] <= 1'b1;
            end else if (res_ovf) begin
                flags[ubd_pkg::FLAG_Z] <= 1'b0;
            end else begin
                acc <= quot[7:0];
                flags[ubd_pkg::FLAG_Z] <= (quot[7:0] == 8'h00);
            end
        end
    end

    // staged opcode bytes and operand registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            insn0 <= ubd_pkg::WORD_RST;
            insn1 <= 8'h00;
            gpr <= ubd_pkg::WORD_RST;
            first_index_reg <= 16'h0000;
            second_index_reg <= 16'h0000;
            stack_ptr <= 16'h0000;
            prog_ctr <= 16'h0000;
        end else if (wr_idle) begin
            unique case (off)
                ubd_pkg::OFF_INSN0: insn0 <= pwdata;
                ubd_pkg::OFF_INSN1: insn1 <= pwdata[7:0];
                ubd_pkg::OFF_GPR: gpr <= pwdata;
                ubd_pkg::OFF_INDEX: begin
                    first_index_reg <= pwdata[15:0];
                    second_index_reg <= pwdata[31:16];
                end
                ubd_pkg::OFF_SPPC: begin
                    stack_ptr <= pwdata[15:0];
                    prog_ctr <= pwdata[31:16];
                end
                default: ;
            endcase
        end
    end

    // sticky status: a hardware set in the same cycle beats a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag <= 1'b0;
            trap_flag <= 1'b0;
            illegal_flag <= 1'b0;
        end else begin
            done_flag <= (state == UBD_S_FINISH)
                || (done_flag && !(wr_status && pwdata[ubd_pkg::ST_DONE]));
            trap_flag <= (state == UBD_S_TRAP)
                || (trap_flag && !(wr_status && pwdata[ubd_pkg::ST_TRAP]));
            illegal_flag <= (state == UBD_S_DECODE && dec_bad)
                || (illegal_flag && !(wr_status && pwdata[ubd_pkg::ST_ILLEGAL]));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            division_trap <= 1'b0;
        end else begin
            division_trap <= (state == UBD_S_FINISH) && (res_zero_div || res_ovf);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data captured in the setup cycle so the access phase needs no wait
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (off)
            ubd_pkg::OFF_STATUS: begin
                rd_mux[ubd_pkg::ST_BUSY] = busy;
                rd_mux[ubd_pkg::ST_DONE] = done_flag;
                rd_mux[ubd_pkg::ST_TRAP] = trap_flag;
                rd_mux[ubd_pkg::ST_ILLEGAL] = illegal_flag;
                rd_mux[ubd_pkg::ST_MEMREQ] = (state == UBD_S_MEMWAIT);
                rd_mux[ubd_pkg::ST_MODE_LSB +: 4] = mode;
            end
            ubd_pkg::OFF_PAIR: rd_mux[15:0] = dividend_pair_reg;
            ubd_pkg::OFF_ACCFLAGS: rd_mux[15:0] = {acc, flags};
            ubd_pkg::OFF_INSN0: rd_mux = insn0;
            ubd_pkg::OFF_INSN1: rd_mux[7:0] = insn1;
            ubd_pkg::OFF_GPR: rd_mux = gpr;
            ubd_pkg::OFF_INDEX: rd_mux = {second_index_reg, first_index_reg};
            ubd_pkg::OFF_SPPC: rd_mux = {prog_ctr, stack_ptr};
            ubd_pkg::OFF_EA: rd_mux[15:0] = eff_addr;
            default: ;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            prdata <= (pwrite || !addr_ok) ? 32'h0000_0000 : rd_mux;
            pslverr <= !addr_ok;
        end
    end
endmodule : ubd_divide

// ---- logic/ubd_pkg.sv ----
// constants, offsets and encodings for the unsigned byte divide unit
package ubd_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_PAIR = 8'h08;
    localparam logic [7:0] OFF_ACCFLAGS = 8'h0c;
    localparam logic [7:0] OFF_INSN0 = 8'h10;
    localparam logic [7:0] OFF_INSN1 = 8'h14;
    localparam logic [7:0] OFF_GPR = 8'h18;
    localparam logic [7:0] OFF_INDEX = 8'h1c;
    localparam logic [7:0] OFF_SPPC = 8'h20;
    localparam logic [7:0] OFF_EA = 8'h24;
    localparam logic [7:0] OFF_MEM = 8'h28;
    // control and status bit positions
    localparam int CTRL_START = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_TRAP = 2;
    localparam int ST_ILLEGAL = 3;
    localparam int ST_MEMREQ = 4;
    localparam int ST_MODE_LSB = 8;
    // flag bit positions inside the flag byte
    localparam int FLAG_S = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_H = 4;
    localparam int FLAG_V = 2;
    localparam int FLAG_N = 1;
    localparam int FLAG_C = 0;
    // reset values
    localparam logic [15:0] PAIR_RST = 16'h0000;
    localparam logic [15:0] ACCFLAGS_RST = 16'h0000;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    // opcode bytes and fields
    localparam logic [7:0] PFX_MAIN = 8'hed;
    localparam logic [7:0] PFX_SECOND = 8'hfd;
    localparam logic [7:0] PFX_FIRST = 8'hdd;
    localparam logic [2:0] TAIL_UNSIGNED_SHORT_DIVIDE = 3'h5;
    localparam logic [1:0] HEAD_OP = 2'h3;
    localparam int PFX_INDEX_BIT = 5;
    localparam logic [2:0] F_PCREL = 3'h0;
    localparam logic [2:0] F_SEL1 = 3'h1;
    localparam logic [2:0] F_SEL2 = 3'h2;
    localparam logic [2:0] F_SEL3 = 3'h3;
    localparam logic [2:0] F_HIGH = 3'h4;
    localparam logic [2:0] F_LOW = 3'h5;
    localparam logic [2:0] F_SHORT = 3'h6;
    localparam logic [2:0] F_CONST = 3'h7;
    localparam logic [2:0] R_MEM = 3'h6;
    localparam logic [2:0] R_ACC = 3'h7;
    // number of shift-subtract steps for a 16-bit dividend
    localparam logic [4:0] DIV_STEPS = 5'h10;
    // addressing modes, reported in the status register
    typedef enum logic [3:0] {
        UBD_M_REG, UBD_M_POINTER, UBD_M_CONST, UBD_M_ABS, UBD_M_INDEXED,
        UBD_M_SHORT, UBD_M_PCREL, UBD_M_STACK, UBD_M_SUM, UBD_M_HALF
    } ubd_mode_t;
endpackage : ubd_pkg

// ---- test/tb_top.sv ----
// self-checking bench for the unsigned byte divide unit
`timescale 1ns/1ps
module tb_top;
    localparam logic [31:0] zw = 32'h0000_0000;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = zw;
    logic [31:0] pwdata = zw;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic division_trap;
    logic [31:0] rd;
    logic rd_err;
    int num_errors = 0;
    int comparisons = 0;
    int trap_cnt = 0;
    ubd_divide i_ubd_divide (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .division_trap(division_trap));
    // 20 MHz clock
    always #25 pclk = ~pclk;
    // trap pulses seen at the port
    always @(posedge pclk) if (division_trap === 1'b1) trap_cnt++;
    ////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task wrap_up;
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    // one transfer, request held until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {24'h00_0000, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            wrap_up();
        end
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // poll a status bit, bounded so a hang ends the run
    task poll(input int b, input logic v);
        int n;
        n = 0;
        do begin
            apb(1'b0, ubd_pkg::OFF_STATUS, zw);
            n++;
        end while (rd[b] !== v && n < 60);
        if (rd[b] !== v) begin
            num_errors++;
            wrap_up();
        end
    endtask : poll
    // one divide; start flags picked so that z has to move, and v too except for a valid zero quotient
    task run_case(input logic [31:0] i0, input logic [7:0] dv, input logic mem,
            input logic [15:0] ea, input logic [15:0] hl);
        logic [15:0] q;
        logic [7:0] r;
        logic [7:0] f;
        logic [7:0] fi;
        logic err;
        int t0;
        q = (dv == 8'h00) ? 16'h0000 : hl / {8'h00, dv};
        r = (dv == 8'h00) ? 8'h00 : 8'(hl % {8'h00, dv});
        err = dv == 8'h00 || q > 16'h00ff;
        fi = (q == 16'h0000) ? 8'hbb : (err ? 8'hf3 : 8'hf7);
        f = fi & 8'h7f;
        if (dv == 8'h00) f = f | 8'h44;
        else if (err) f = (f & 8'hbf) | 8'h04;
        else f = (f & 8'hbb) | ((q == 16'h0000) ? 8'h40 : 8'h00);
        apb(1'b1, ubd_pkg::OFF_PAIR, {16'h0000, hl});
        apb(1'b1, ubd_pkg::OFF_ACCFLAGS, {16'h0000, 8'h0d, fi});
        apb(1'b1, ubd_pkg::OFF_INSN0, i0);
        apb(1'b1, ubd_pkg::OFF_INSN1, 32'h0000_0001);
        apb(1'b1, ubd_pkg::OFF_STATUS, 32'h0000_000e);
        t0 = trap_cnt;
        apb(1'b1, ubd_pkg::OFF_CTRL, 32'h0000_0001);
        if (mem) begin
            poll(ubd_pkg::ST_MEMREQ, 1'b1);
            apb(1'b0, ubd_pkg::OFF_EA, zw);
            check(rd, {16'h0000, ea});
            apb(1'b1, ubd_pkg::OFF_MEM, {24'h00_0000, dv});
        end
        poll(ubd_pkg::ST_BUSY, 1'b0);
        apb(1'b0, ubd_pkg::OFF_ACCFLAGS, zw);
        check(rd, {16'h0000, err ? 8'h0d : q[7:0], f});
        apb(1'b0, ubd_pkg::OFF_PAIR, zw);
        check(rd, {16'h0000, hl[15:8], err ? hl[7:0] : r});
        apb(1'b0, ubd_pkg::OFF_STATUS, zw);
        check({30'h0000_0000, rd[ubd_pkg::ST_TRAP -: 2]}, {30'h0000_0000, err, 1'b1});
        check(32'(trap_cnt - t0), {31'h0000_0000, err});
    endtask : run_case
    ////////////////////////////////////////////////////////////////////////
    // reset values, unmapped and unaligned addresses
    task reset_check;
        apb(1'b0, ubd_pkg::OFF_ACCFLAGS, zw);
        check(rd, zw);
        apb(1'b0, ubd_pkg::OFF_CTRL, zw);
        check(rd, zw);
        apb(1'b0, 8'h2c, zw);
        check({31'h0000_0000, rd_err}, 32'h0000_0001);
        apb(1'b1, 8'h09, 32'h0000_ffff);
        check({31'h0000_0000, rd_err}, 32'h0000_0001);
        apb(1'b1, ubd_pkg::OFF_GPR, 32'h1020_0300);
        apb(1'b1, ubd_pkg::OFF_INDEX, 32'h2010_1008);
        apb(1'b1, ubd_pkg::OFF_SPPC, 32'h4000_3000);
    endtask : reset_check
    // every register source, all three outcomes
    task reg_form;
        logic [7:0] dvs [8] = '{8'h10, 8'h20, 8'h03, 8'h00, 8'h06, 8'h40, 8'h00, 8'h0d};
        for (int i = 0; i < 8; i++) begin
            if (i != 6) run_case({16'h0000, 2'b11, 3'(i), 3'b101, 8'hed}, dvs[i], 1'b0,
                16'h0000, 16'h0640);
        end
    endtask : reg_form
    // immediate divisor at quotient 0, ff and overflow
    task const_form;
        run_case(32'h10fd_edfd, 8'h10, 1'b0, 16'h0000, 16'h0005);
        run_case(32'hfffd_edfd, 8'hff, 1'b0, 16'h0000, 16'hfeff);
        run_case(32'hfffd_edfd, 8'hff, 1'b0, 16'h0000, 16'hffff);
    endtask : const_form
    task half_form;
        run_case(32'h00e5_eddd, 8'h10, 1'b0, 16'h0000, 16'h0640);
        run_case(32'h00ed_eddd, 8'h08, 1'b0, 16'h0000, 16'h0640);
        run_case(32'h00e5_edfd, 8'h20, 1'b0, 16'h0000, 16'h0640);
        run_case(32'h00ed_edfd, 8'h10, 1'b0, 16'h0000, 16'h0640);
    endtask : half_form
    task mem_form;
        logic [31:0] ops [11] = '{32'h0000_f5ed, 32'h02fd_eddd, 32'h02cd_edfd, 32'h02d5_edfd,
            32'h02dd_edfd, 32'h02c5_edfd, 32'h02c5_eddd, 32'h00cd_eddd, 32'h00d5_eddd,
            32'h00dd_eddd, 32'h02f5_eddd};
        logic [15:0] eas [11] = '{16'h0640, 16'h0102, 16'h110a, 16'h2112, 16'h0742,
            16'h4102, 16'h3102, 16'h1648, 16'h2650, 16'h3018, 16'h100a};
        for (int i = 0; i < 11; i++) run_case(ops[i], 8'h10, 1'b1, eas[i], 16'h0640);
    endtask : mem_form
    // unknown opcode is refused with no divide and no trap
    task bad_opcode;
        apb(1'b1, ubd_pkg::OFF_STATUS, 32'h0000_000e);
        apb(1'b1, ubd_pkg::OFF_INSN0, 32'h0000_00ff);
        apb(1'b1, ubd_pkg::OFF_CTRL, 32'h0000_0001);
        poll(ubd_pkg::ST_BUSY, 1'b0);
        apb(1'b0, ubd_pkg::OFF_STATUS, zw);
        check(rd & 32'h0000_000f, 32'h0000_0008);
    endtask : bad_opcode
    task keep_source;
        apb(1'b0, ubd_pkg::OFF_GPR, zw);
        check(rd, 32'h1020_0300);
        apb(1'b0, ubd_pkg::OFF_INDEX, zw);
        check(rd, 32'h2010_1008);
    endtask : keep_source
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        reset_check();
        reg_form();
        const_form();
        half_form();
        mem_form();
        bad_opcode();
        keep_source();
        wrap_up();
    end
endmodule : tb_top
bind ubd_divide ubd_divide_sva i_ubd_divide_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .division_trap(division_trap));

// ---- test/ubd_divide_sva.sv ----
// port-level assertions for the unsigned byte divide unit
`timescale 1ns/1ps
module ubd_divide_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic division_trap
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic bad_addr;
    logic [7:0] since_start;
    ////////////////////////////////////////////////////////////////////////
    // address outside the map or not word aligned
    assign bad_addr = paddr[1:0] != 2'h0 || paddr[31:8] != 24'h00_0000 ||
        paddr[7:0] > ubd_pkg::OFF_MEM;
    // edges since the last start write, saturating so long waits stay legal
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_start <= 8'h00;
        end else if (psel && penable && pwrite && paddr == 32'h0000_0000 && pwdata[0]) begin
            since_start <= 8'h00;
        end else if (since_start != 8'hff) begin
            since_start <= since_start + 8'h01;
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_bad;
        s_setup ##0 bad_addr;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_ready_high: assert property (pready) else $error("pready low");
    a_bad_err: assert property (s_bad |=> pslverr && prdata == 32'h0000_0000)
        else $error("bad address not refused");
    a_good_ok: assert property (s_setup ##0 !bad_addr |=> !pslverr)
        else $error("mapped address refused");
    a_ctrl_zero: assert property (s_setup ##0 (!pwrite && paddr == 32'h0000_0000)
        |=> prdata == 32'h0000_0000) else $error("control read not zero");
    a_write_zero: assert property (s_setup ##0 pwrite |=> prdata == 32'h0000_0000)
        else $error("write returned data");
    a_read_hold: assert property (!(psel && !penable) |=> $stable(prdata) && $stable(pslverr))
        else $error("read answer moved outside setup");
    a_trap_pulse: assert property (division_trap |=> !division_trap [*2])
        else $error("trap not a single pulse");
    a_trap_cause: assert property (division_trap |-> since_start >= 8'h01)
        else $error("trap without a started divide");
endmodule : ubd_divide_sva
